// ==== core/motor_current_protection.sv ====
`timescale 1ns/1ns
module motor_current_protection
  import motor_protect_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // parameter update from host link
  input wire logic param_write_i,
  input wire motor_params_type param_data_i,
  input wire logic drive_enable_i,
  input wire logic fault_reset_i,
  // loop signals
  input wire logic [CUR_W-1:0] current_command_i,
  input wire logic [CUR_W-1:0] measured_current_i,
  input wire logic signed [ERR_W-1:0] follow_error_i,
  // outputs
  output logic [CUR_W-1:0] current_out_o,
  output logic [GAIN_W-1:0] prop_gain_eff_o,
  output logic [GAIN_W-1:0] integ_gain_eff_o,
  output motor_params_type params_o,
  output protect_status_type status_o
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [GAIN_W-1:0] pct_clamp(input logic [GAIN_W-1:0] g);
    pct_clamp = (g > GAIN_PCT_MAX) ? GAIN_PCT_MAX : g;
  endfunction : pct_clamp

  // master gain in percent; result kept within 0..100
  function automatic logic [GAIN_W-1:0] scale(input logic [GAIN_W-1:0] g,
                                              input logic [GAIN_W-1:0] m);
    logic [2*GAIN_W-1:0] prod;
    prod = (g * m) / MASTER_UNITY;
    scale = (prod > (2*GAIN_W)'(GAIN_PCT_MAX)) ? GAIN_PCT_MAX : prod[GAIN_W-1:0];
  endfunction : scale

  function automatic logic [CUR_W-1:0] sat_sub(input logic [CUR_W-1:0] a,
                                               input logic [CUR_W-1:0] b);
    sat_sub = (a > b) ? a - b : CUR_ZERO;
  endfunction : sat_sub

  ////////////////////////////////////////////////////////////////////////////
  motor_params_type params;
  motor_params_type next_params;
  logic [CUR_W-1:0] fold_ceiling;
  logic [CUR_W-1:0] current_out;
  logic follow_fault;
  logic low_speed_trip;
  logic rejected;

  wire accept_write = param_write_i && !drive_enable_i;
  wire reject_write = param_write_i && drive_enable_i;

  wire [CUR_W-1:0] lim_in = (param_data_i.current_limit > MODEL_MAX_CURRENT) ?
                            MODEL_MAX_CURRENT : param_data_i.current_limit;

  always_comb begin
    next_params = param_data_i;
    next_params.current_limit = lim_in;
    next_params.prop_gain = pct_clamp(param_data_i.prop_gain);
    next_params.integ_gain = pct_clamp(param_data_i.integ_gain);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      params <= '{mode: MODE_CURRENT, default: '0};
      rejected <= 1'b0;
    end else begin
      if (accept_write) begin
        params <= next_params;
      end
      rejected <= reject_write || (rejected && !accept_write);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // foldback disabled conditions
  wire fold_armed = params.foldback_enable &&
                    (params.foldback_threshold < params.current_limit);
  wire fold_over = fold_armed && (measured_current_i > params.foldback_threshold);

  // ceiling ramps down while over, snaps back once below; nothing latched
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fold_ceiling <= CUR_ZERO;
    end else if (fold_over) begin
      fold_ceiling <= sat_sub(fold_ceiling, params.foldback_rate);
    end else begin
      fold_ceiling <= params.current_limit;
    end
  end

  // clamp to peak limit and foldback ceiling
  wire [CUR_W-1:0] lim_cmd = (current_command_i > params.current_limit) ?
                             params.current_limit : current_command_i;
  wire [CUR_W-1:0] next_current_out = (fold_over && lim_cmd > fold_ceiling) ?
                                      fold_ceiling : lim_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // following check in position mode only
  wire [ERR_W-1:0] err_mag = follow_error_i[ERR_W-1] ? ERR_W'(-follow_error_i) :
                             ERR_W'(follow_error_i);
  wire follow_hit = (params.mode == MODE_POSITION) && (err_mag > params.follow_limit);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      follow_fault <= 1'b0;
      current_out <= CUR_ZERO;
    end else begin
      follow_fault <= follow_hit || (follow_fault && !fault_reset_i);
      current_out <= next_current_out;
    end
  end

  breaker_timer u_breaker (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .trip_current_i(params.breaker_trip_current),
    .trip_time_i(params.breaker_trip_time),
    .measured_i(measured_current_i),
    .clear_i(fault_reset_i),
    .timer_o(),
    .trip_o(low_speed_trip)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master gain on both gains
  wire [GAIN_W-1:0] next_prop = scale(params.prop_gain, params.master_gain);
  wire [GAIN_W-1:0] next_integ = scale(params.integ_gain, params.master_gain);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prop_gain_eff_o <= '0;
      integ_gain_eff_o <= '0;
      params_o <= '{mode: MODE_CURRENT, default: '0};
      status_o <= '0;
    end else begin
      prop_gain_eff_o <= next_prop;
      integ_gain_eff_o <= next_integ;
      params_o <= params;
      status_o <= '{follow_fault: follow_fault, low_speed_fault: low_speed_trip,
                    foldback_active: fold_over, update_rejected: rejected};
    end
  end

  assign current_out_o = current_out;
endmodule : motor_current_protection

// ==== inc/motor_protect_pkg.sv ====
// Overview of operation
// - clamp commanded current to the configured peak limit, zero up to model maximum
// - in position mode raise following fault when count error exceeds limit
// - following-error check active only in position mode, ignored otherwise
// - current above breaker trip level advances filter timer at base rate
// - current below breaker trip level decrements filter timer at double rate
// - timer above trip time raises low-speed fault, latched until fault reset
// - above foldback threshold, ramp output current down at foldback rate
// - foldback never latches; releases once current falls below threshold
// - foldback disabled when threshold at or above limit, or enable cleared
// - proportional and integral gains accepted as percentages 0 to 100
// - master gain scales both proportional and integral gains
// - host disables motor first; device rejects updates while motor enabled
package motor_protect_pkg;
  localparam int CUR_W = 16;
  localparam int ERR_W = 24;
  localparam int TMR_W = 24;
  localparam int GAIN_W = 8;
  localparam logic [CUR_W-1:0] MODEL_MAX_CURRENT = 16'hffff;
  localparam logic [GAIN_W-1:0] GAIN_PCT_MAX = 8'h64;
  localparam logic [GAIN_W-1:0] MASTER_UNITY = 8'h64;
  localparam logic [TMR_W-1:0] TMR_UP_STEP = 24'h000001;
  localparam logic [TMR_W-1:0] TMR_DOWN_STEP = 24'h000002;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [CUR_W-1:0] CUR_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    MODE_CURRENT = 3'b001,
    MODE_VELOCITY = 3'b010,
    MODE_POSITION = 3'b100
  } drive_mode_type;

  typedef struct packed {
    logic [CUR_W-1:0] current_limit;
    logic [ERR_W-1:0] follow_limit;
    logic [CUR_W-1:0] breaker_trip_current;
    logic [TMR_W-1:0] breaker_trip_time;
    logic [CUR_W-1:0] foldback_threshold;
    logic [CUR_W-1:0] foldback_rate;
    logic foldback_enable;
    logic [GAIN_W-1:0] prop_gain;
    logic [GAIN_W-1:0] integ_gain;
    logic [GAIN_W-1:0] master_gain;
    drive_mode_type mode;
  } motor_params_type;

  typedef struct packed {
    logic follow_fault;
    logic low_speed_fault;
    logic foldback_active;
    logic update_rejected;
  } protect_status_type;
endpackage : motor_protect_pkg

// ==== core/breaker_timer.sv ====
`timescale 1ns/1ns
module breaker_timer
  import motor_protect_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // configuration and sample
  input wire logic [CUR_W-1:0] trip_current_i,
  input wire logic [TMR_W-1:0] trip_time_i,
  input wire logic [CUR_W-1:0] measured_i,
  input wire logic clear_i,
  // result
  output logic [TMR_W-1:0] timer_o,
  output logic trip_o
);
  logic [TMR_W-1:0] timer;
  logic [TMR_W-1:0] next_timer;
  wire above = measured_i > trip_current_i;
  wire below = measured_i < trip_current_i;
  wire at_floor = timer < TMR_DOWN_STEP;
  wire at_ceiling = timer == {TMR_W{1'b1}};

  // up at base, down twice, floor zero
  always_comb begin
    next_timer = timer;
    if (above && !at_ceiling) begin
      next_timer = timer + TMR_UP_STEP;
    end else if (below) begin
      next_timer = at_floor ? TMR_ZERO : timer - TMR_DOWN_STEP;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      timer <= TMR_ZERO;
      trip_o <= 1'b0;
    end else begin
      timer <= clear_i ? TMR_ZERO : next_timer;
      trip_o <= !clear_i && (trip_o || timer > trip_time_i);
    end
  end

  assign timer_o = timer;
endmodule : breaker_timer

// ==== sim/host_param_model.sv ====
`timescale 1ns/1ns
module host_param_model
  import motor_protect_pkg::*;
(
  input wire logic clk_sys_i,
  output logic drive_enable_o,
  output logic param_write_o,
  output motor_params_type param_data_o
);
  int saves = 0;
  initial begin
    drive_enable_o = 1'b0;
    param_write_o = 1'b0;
    param_data_o = '0;
  end
  task automatic send(input motor_params_type p, input logic keep_on);
    @(posedge clk_sys_i) drive_enable_o <= keep_on;
    @(posedge clk_sys_i) param_write_o <= 1'b1;
    param_data_o <= p;
    @(posedge clk_sys_i) param_write_o <= 1'b0;
    param_data_o <= ~p;
    drive_enable_o <= 1'b0;
    saves++;
  endtask : send
endmodule : host_param_model

// ==== sim/motor_current_protection_sva.sv ====
`timescale 1ns/1ns
module motor_current_protection_sva
  import motor_protect_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic param_write_i,
  input wire motor_params_type param_data_i,
  input wire logic drive_enable_i,
  input wire logic [CUR_W-1:0] measured_current_i,
  input wire logic signed [ERR_W-1:0] follow_error_i,
  input wire logic [CUR_W-1:0] current_out_o,
  input wire logic [GAIN_W-1:0] prop_gain_eff_o,
  input wire logic [GAIN_W-1:0] integ_gain_eff_o,
  input wire motor_params_type params_o,
  input wire protect_status_type status_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic armed = params_o.foldback_enable && params_o.foldback_threshold < params_o.current_limit;
  wire logic over = measured_current_i > params_o.foldback_threshold;
  wire logic pos = params_o.mode == MODE_POSITION;
  sequence s_take; param_write_i && !drive_enable_i ##1 !param_write_i; endsequence
  property p_clamp; current_out_o <= params_o.current_limit; endproperty
  property p_follow;
    pos && !follow_error_i[ERR_W-1] && $unsigned(follow_error_i) > params_o.follow_limit
      |-> ##2 status_o.follow_fault;
  endproperty
  property p_mode; $rose(status_o.follow_fault) |-> pos; endproperty
  property p_foldon; armed && over |=> status_o.foldback_active; endproperty
  property p_foldoff; !over |=> !status_o.foldback_active; endproperty
  property p_gain; prop_gain_eff_o <= GAIN_PCT_MAX && integ_gain_eff_o <= GAIN_PCT_MAX; endproperty
  property p_reject; param_write_i && drive_enable_i |-> ##2 status_o.update_rejected; endproperty
  property p_take;
    s_take |-> ##1 params_o.current_limit == $past(param_data_i.current_limit, 2);
  endproperty
  a_clamp: assert property (p_clamp) else $error("output above limit");
  a_follow: assert property (p_follow) else $error("no following fault");
  a_mode: assert property (p_mode) else $error("fault outside position mode");
  a_foldon: assert property (p_foldon) else $error("foldback missing");
  a_foldoff: assert property (p_foldoff) else $error("foldback held");
  a_gain: assert property (p_gain) else $error("gain above full scale");
  a_reject: assert property (p_reject) else $error("write not refused");
  a_take: assert property (p_take) else $error("write not taken");
endmodule : motor_current_protection_sva
bind motor_current_protection motor_current_protection_sva sva (.clk_sys_i, .reset_i,
  .param_write_i, .param_data_i, .drive_enable_i, .measured_current_i, .follow_error_i,
  .current_out_o, .prop_gain_eff_o, .integ_gain_eff_o, .params_o, .status_o);

// ==== sim/tb_motor_current_protection.sv ====
`timescale 1ns/1ns
module tb_motor_current_protection;
  import motor_protect_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fault_reset_i = 1'b0;
  logic [CUR_W-1:0] cmd = '0;
  logic [CUR_W-1:0] meas = '0;
  logic signed [ERR_W-1:0] ferr = '0;
  logic param_write_i;
  logic drive_enable_i;
  motor_params_type param_data_i;
  logic [CUR_W-1:0] current_out_o;
  logic [GAIN_W-1:0] prop_gain_eff_o;
  logic [GAIN_W-1:0] integ_gain_eff_o;
  motor_params_type params_o;
  protect_status_type status_o;
  motor_params_type p;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  host_param_model host (.clk_sys_i, .drive_enable_o(drive_enable_i),
    .param_write_o(param_write_i), .param_data_o(param_data_i));
  motor_current_protection dut (.clk_sys_i, .reset_i, .param_write_i, .param_data_i,
    .drive_enable_i, .fault_reset_i, .current_command_i(cmd), .measured_current_i(meas),
    .follow_error_i(ferr), .current_out_o, .prop_gain_eff_o, .integ_gain_eff_o,
    .params_o, .status_o);
  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_n
  task automatic drive(input int c, input int m, input int n);
    @(posedge clk_sys_i);
    cmd <= c[CUR_W-1:0];
    meas <= m[CUR_W-1:0];
    wait_n(n);
  endtask : drive
  task automatic clear_faults();
    @(posedge clk_sys_i) fault_reset_i <= 1'b1;
    @(posedge clk_sys_i) fault_reset_i <= 1'b0;
    wait_n(4);
  endtask : clear_faults
  task automatic send(input logic keep_on);
    host.send(p, keep_on);
    wait_n(3);
  endtask : send
  ////////////////////////////////////////////////////////////////
  task automatic t_params();
    p = '{current_limit: 16'h03e8, follow_limit: 24'h000010, breaker_trip_current: 16'h0064,
      breaker_trip_time: 24'h000006, foldback_threshold: 16'h01f4, foldback_rate: 16'h0064,
      foldback_enable: 1'b0, prop_gain: 8'h50, integ_gain: 8'h64, master_gain: 8'h32,
      mode: MODE_CURRENT};
    send(1'b0);
    chk(params_o.current_limit, 16'h03e8);
    chk(prop_gain_eff_o, 8'h28);
    chk(integ_gain_eff_o, 8'h32);
    p.master_gain = 8'h96;
    send(1'b0);
    chk(prop_gain_eff_o, 8'h64);
    p.current_limit = 16'h0200;
    send(1'b1);
    chk(status_o.update_rejected, 1'b1);
    chk(params_o.current_limit, 16'h03e8);
    p.current_limit = 16'h03e8;
  endtask : t_params
  task automatic t_clamp();
    drive(2000, 0, 2);
    chk(current_out_o, 16'h03e8);
    drive(300, 0, 2);
    chk(current_out_o, 16'h012c);
  endtask : t_clamp
  // slow decrement or a wrap trips early
  task automatic t_breaker();
    drive(0, 200, 4);
    drive(0, 50, 2);
    drive(0, 200, 5);
    drive(0, 100, 4);
    chk(status_o.low_speed_fault, 1'b0);
    drive(0, 200, 1);
    drive(0, 0, 4);
    chk(status_o.low_speed_fault, 1'b1);
    wait_n(6);
    chk(status_o.low_speed_fault, 1'b1);
    clear_faults();
    chk(status_o.low_speed_fault, 1'b0);
  endtask : t_breaker
  task automatic t_follow();
    @(posedge clk_sys_i) ferr <= 24'sh000100;
    wait_n(4);
    chk(status_o.follow_fault, 1'b0);
    @(posedge clk_sys_i) ferr <= '0;
    p.mode = MODE_POSITION;
    send(1'b0);
    @(posedge clk_sys_i) ferr <= 24'sh000100;
    wait_n(4);
    chk(status_o.follow_fault, 1'b1);
    @(posedge clk_sys_i) ferr <= '0;
    clear_faults();
  endtask : t_follow
  task automatic t_fold();
    p.foldback_enable = 1'b1;
    send(1'b0);
    drive(800, 600, 2);
    chk(status_o.foldback_active, 1'b1);
    wait_n(4);
    chk(current_out_o < 16'h0320, 1'b1);
    drive(800, 400, 3);
    chk(status_o.foldback_active, 1'b0);
    chk(current_out_o, 16'h0320);
    drive(0, 0, 1);
    p.foldback_threshold = 16'h03e8;
    send(1'b0);
    drive(800, 1200, 3);
    chk(status_o.foldback_active, 1'b0);
  endtask : t_fold
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    wait_n(1);
    t_params();
    t_clamp();
    t_breaker();
    t_follow();
    t_fold();
    report_and_stop();
  end
endmodule : tb_motor_current_protection
